// file: common/mpc_params.svh
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH

// pin population and banks
`define MPC_NPINS 26
`define MPC_LO_PINS 14

// register bank base offsets
`define MPC_MODE_LO 16'hf510
`define MPC_MODE_HI 16'hf5c0
`define MPC_WRITE_LO 16'hf520
`define MPC_WRITE_HI 16'hf5d0
`define MPC_READ_LO 16'hf530
`define MPC_READ_HI 16'hf5e0

// pin_function_config field layout
`define MPC_EN_BIT 0
`define MPC_MODE_MSB 3
`define MPC_MODE_LSB 1
`define MPC_DEB_MSB 7
`define MPC_DEB_LSB 4
`define MPC_SS_MSB 10
`define MPC_SS_LSB 8
`define MPC_CFG_W 11
`define MPC_CFG_RST 11'h000
`define MPC_VAL_RST 1'b0
`define MPC_SS_CHANNELS 6

// debounce codes
`define MPC_DEB_0P3 4'h1
`define MPC_DEB_0P6 4'h2
`define MPC_DEB_0P9 4'h3
`define MPC_DEB_5P0 4'h4
`define MPC_DEB_10 4'h5
`define MPC_DEB_20 4'h6
`define MPC_DEB_40 4'h7

// timing: core clock rate and debounce times in microseconds
`define MPC_CLK_MHZ 200
`define MPC_DEB_0P3_US 300
`define MPC_DEB_0P6_US 600
`define MPC_DEB_0P9_US 900
`define MPC_DEB_5P0_US 5000
`define MPC_DEB_10_US 10000
`define MPC_DEB_20_US 20000
`define MPC_DEB_40_US 40000
`define MPC_DEB_0P3_CYC (`MPC_DEB_0P3_US * `MPC_CLK_MHZ)
`define MPC_DEB_0P6_CYC (`MPC_DEB_0P6_US * `MPC_CLK_MHZ)
`define MPC_DEB_0P9_CYC (`MPC_DEB_0P9_US * `MPC_CLK_MHZ)
`define MPC_DEB_5P0_CYC (`MPC_DEB_5P0_US * `MPC_CLK_MHZ)
`define MPC_DEB_10_CYC (`MPC_DEB_10_US * `MPC_CLK_MHZ)
`define MPC_DEB_20_CYC (`MPC_DEB_20_US * `MPC_CLK_MHZ)
`define MPC_DEB_40_CYC (`MPC_DEB_40_US * `MPC_CLK_MHZ)
`define MPC_CNT_W 24

`endif

// file: common/mpc_pkg.sv
package mpc_pkg;

  typedef enum logic [2:0]
  {
    MPC_GP_IN = 3'h0,
    MPC_CP_IN = 3'h1,
    MPC_OUT_PU = 3'h2,
    MPC_OUT_NOPU = 3'h3,
    MPC_PDM_IN = 3'h4,
    MPC_FAULT_OUT = 3'h5,
    MPC_SS_OUT = 3'h6
  } mpc_mode_type;

  typedef enum logic [1:0]
  {
    MPC_DEB_STABLE = 2'h1,
    MPC_DEB_COUNT = 2'h2
  } mpc_deb_state_type;

endpackage

// file: common/mpc_deb_if.sv
`timescale 1ns/1ps
interface mpc_deb_if #(parameter int CNT_W = 24);
  logic raw;
  logic [CNT_W-1:0] limit;
  logic stable;

  modport filt (input raw, input limit, output stable);
  modport user (output raw, output limit, input stable);
endinterface

// file: design/mpc_debounce.sv
`timescale 1ns/1ps
`include "mpc_params.svh"
module mpc_debounce #(
  parameter int CNT_W = `MPC_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  mpc_deb_if.filt deb
);

  mpc_pkg::mpc_deb_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic stable_q;

  wire differ_w = deb.raw != stable_q;
  wire zero_w = deb.limit == '0;
  wire short_w = deb.limit <= CNT_W'(1);
  // a limit lowered to zero or one mid-count ends the count at once
  wire last_w = short_w || cnt_q >= CNT_W'(deb.limit - CNT_W'(1));

  assign deb.stable = stable_q;

  // a count in progress restarts whenever the input bounces back
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= mpc_pkg::MPC_DEB_STABLE;
      cnt_q <= '0;
      stable_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        mpc_pkg::MPC_DEB_STABLE:
        begin
          if (differ_w && short_w)
            stable_q <= deb.raw;
          else if (differ_w)
          begin
            state_q <= mpc_pkg::MPC_DEB_COUNT;
            cnt_q <= CNT_W'(1);
          end
        end
        mpc_pkg::MPC_DEB_COUNT:
        begin
          if (!differ_w)
          begin
            state_q <= mpc_pkg::MPC_DEB_STABLE;
            cnt_q <= '0;
          end
          else if (last_w)
          begin
            stable_q <= deb.raw;
            state_q <= mpc_pkg::MPC_DEB_STABLE;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + CNT_W'(1);
        end
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence quiet_s;
    state_q == mpc_pkg::MPC_DEB_COUNT && differ_w && !last_w;
  endsequence

  deb_pass_a: assert property (
    (zero_w && differ_w) |=> stable_q == $past(deb.raw))
    else $error("zero debounce did not pass input through");
  deb_hold_a: assert property (
    quiet_s |=> $stable(stable_q))
    else $error("debounced level moved before the count ran out");
  deb_cause_a: assert property (
    !$stable(stable_q) |-> $past(differ_w))
    else $error("debounced level moved without an input change");

endmodule

// file: design/mpc_pin_config.sv
`timescale 1ns/1ps
`include "mpc_params.svh"
module mpc_pin_config #(
  parameter int CNT_W = `MPC_CNT_W,
  parameter int DEB_0P3_CYC = `MPC_DEB_0P3_CYC,
  parameter int DEB_0P6_CYC = `MPC_DEB_0P6_CYC,
  parameter int DEB_0P9_CYC = `MPC_DEB_0P9_CYC,
  parameter int DEB_5P0_CYC = `MPC_DEB_5P0_CYC,
  parameter int DEB_10_CYC = `MPC_DEB_10_CYC,
  parameter int DEB_20_CYC = `MPC_DEB_20_CYC,
  parameter int DEB_40_CYC = `MPC_DEB_40_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [`MPC_NPINS-1:0] i_pin_in,
  output logic [`MPC_NPINS-1:0] o_pin_out,
  output logic [`MPC_NPINS-1:0] o_pin_oe,
  output logic [`MPC_NPINS-1:0] o_pin_pullup,
  input wire logic [`MPC_NPINS-1:0] i_prim_out,
  input wire logic [`MPC_NPINS-1:0] i_prim_oe,
  input wire logic [`MPC_NPINS-1:0] i_core_out,
  input wire logic i_fault_flag,
  input wire logic [`MPC_SS_CHANNELS-1:0] i_ss_chan,
  output logic [`MPC_NPINS-1:0] o_core_level,
  output logic [`MPC_NPINS-1:0] o_pdm_data,
  output logic [`MPC_NPINS-1:0] o_alt_enabled
);

  localparam int NP = `MPC_NPINS;
  localparam int CW = `MPC_CFG_W;

  // returns {hit, pin}; low bank holds pins 0..13, high bank the rest
  function automatic logic [5:0] pin_slot(input logic [15:0] a,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] dl;
    logic [15:0] dh;
    logic [5:0] r;
    dl = a - lo;
    dh = a - hi;
    r = 6'h00;
    if (a >= lo && dl < 16'(`MPC_LO_PINS))
      r = {1'b1, dl[4:0]};
    else if (a >= hi && dh < 16'(`MPC_NPINS - `MPC_LO_PINS))
      r = {1'b1, 5'(dh[4:0] + 5'(`MPC_LO_PINS))};
    return r;
  endfunction

  // unlisted codes 0 and 8..15 fall back to no debounce
  function automatic logic [CNT_W-1:0] deb_limit(input logic [3:0] code);
    logic [CNT_W-1:0] r;
    r = '0;
    case (code)
      `MPC_DEB_0P3: r = CNT_W'(DEB_0P3_CYC);
      `MPC_DEB_0P6: r = CNT_W'(DEB_0P6_CYC);
      `MPC_DEB_0P9: r = CNT_W'(DEB_0P9_CYC);
      `MPC_DEB_5P0: r = CNT_W'(DEB_5P0_CYC);
      `MPC_DEB_10: r = CNT_W'(DEB_10_CYC);
      `MPC_DEB_20: r = CNT_W'(DEB_20_CYC);
      `MPC_DEB_40: r = CNT_W'(DEB_40_CYC);
      default: r = '0;
    endcase
    return r;
  endfunction

  logic [CW-1:0] cfg_q [NP];
  logic [NP-1:0] forced_q;
  logic [NP-1:0] level_q;
  logic [15:0] rdata_q;
  logic [NP-1:0] pin_out_q;
  logic [NP-1:0] pin_oe_q;
  logic [NP-1:0] pullup_q;
  logic [NP-1:0] core_q;
  logic [NP-1:0] pdm_q;
  logic [NP-1:0] alt_q;

  logic [NP-1:0] en_w;
  logic [NP-1:0] ss_w;
  logic [NP-1:0] stable_w;
  logic [NP-1:0] in_mode_w;
  logic [NP-1:0] pin_out_d;
  logic [NP-1:0] pin_oe_d;
  logic [NP-1:0] pullup_d;
  logic [NP-1:0] core_d;
  logic [NP-1:0] pdm_d;
  logic [NP-1:0] level_d;
  mpc_pkg::mpc_mode_type mode_w [NP];

  wire [5:0] mode_slot_w = pin_slot(i_addr, `MPC_MODE_LO, `MPC_MODE_HI);
  wire [5:0] wr_slot_w = pin_slot(i_addr, `MPC_WRITE_LO, `MPC_WRITE_HI);
  wire [5:0] rd_slot_w = pin_slot(i_addr, `MPC_READ_LO, `MPC_READ_HI);
  wire mode_hit_w = mode_slot_w[5];
  wire wr_hit_w = wr_slot_w[5];
  wire rd_hit_w = rd_slot_w[5];
  wire [CW-1:0] rd_cfg_w = cfg_q[mode_slot_w[4:0]];
  wire rd_level_w = level_q[rd_slot_w[4:0]];

  // write-value addresses and unmapped space read back as zero
  wire [15:0] rdata_d = !i_rd ? 16'h0000 :
                        mode_hit_w ? {5'h00, rd_cfg_w} :
                        rd_hit_w ? {15'h0000, rd_level_w} :
                        16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      mpc_deb_if #(.CNT_W(CNT_W)) deb ();
      logic [2:0] ss_sel;

      assign en_w[gi] = cfg_q[gi][`MPC_EN_BIT];
      assign mode_w[gi] = mpc_pkg::mpc_mode_type'(
        cfg_q[gi][`MPC_MODE_MSB:`MPC_MODE_LSB]);
      assign ss_sel = cfg_q[gi][`MPC_SS_MSB:`MPC_SS_LSB];
      assign deb.raw = i_pin_in[gi];
      assign deb.limit = deb_limit(
        cfg_q[gi][`MPC_DEB_MSB:`MPC_DEB_LSB]);
      assign stable_w[gi] = deb.stable;

      mpc_debounce #(.CNT_W(CNT_W)) u_deb (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .deb(deb)
      );

      // codes above channel 6 leave the line deasserted high
      assign ss_w[gi] = (ss_sel < 3'(`MPC_SS_CHANNELS)) ?
                        i_ss_chan[ss_sel] : 1'b1;

      assign in_mode_w[gi] = en_w[gi] &&
                             (mode_w[gi] == mpc_pkg::MPC_GP_IN ||
                              mode_w[gi] == mpc_pkg::MPC_CP_IN ||
                              mode_w[gi] == mpc_pkg::MPC_PDM_IN);

      assign pin_oe_d[gi] = !en_w[gi] ? i_prim_oe[gi] :
                            (mode_w[gi] == mpc_pkg::MPC_OUT_PU ||
                             mode_w[gi] == mpc_pkg::MPC_OUT_NOPU ||
                             mode_w[gi] == mpc_pkg::MPC_FAULT_OUT ||
                             mode_w[gi] == mpc_pkg::MPC_SS_OUT);

      assign pin_out_d[gi] = !en_w[gi] ? i_prim_out[gi] :
        (mode_w[gi] == mpc_pkg::MPC_FAULT_OUT) ? i_fault_flag :
        (mode_w[gi] == mpc_pkg::MPC_SS_OUT) ? ss_w[gi] :
        i_core_out[gi];

      assign pullup_d[gi] = en_w[gi] &&
                            mode_w[gi] == mpc_pkg::MPC_OUT_PU;

      // the core sees the debounced level only in plain input mode
      assign core_d[gi] = !en_w[gi] ? 1'b0 :
        (mode_w[gi] == mpc_pkg::MPC_GP_IN) ? stable_w[gi] :
        (mode_w[gi] == mpc_pkg::MPC_CP_IN) ? forced_q[gi] :
        (mode_w[gi] == mpc_pkg::MPC_PDM_IN) ? i_pin_in[gi] :
        1'b0;

      assign pdm_d[gi] = en_w[gi] && mode_w[gi] == mpc_pkg::MPC_PDM_IN &&
                         i_pin_in[gi];

      // last input level is held while the pin is not an input
      assign level_d[gi] = !in_mode_w[gi] ? level_q[gi] :
        (mode_w[gi] == mpc_pkg::MPC_GP_IN) ? stable_w[gi] : i_pin_in[gi];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int k = 0; k < NP; k++)
        cfg_q[k] <= `MPC_CFG_RST;
    end
    else if (i_wr && mode_hit_w)
      cfg_q[mode_slot_w[4:0]] <= i_wdata[CW-1:0];
  end

  // value registers accept writes even while the pin is disabled
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      forced_q <= '0;
    else if (i_wr && wr_hit_w)
      forced_q[wr_slot_w[4:0]] <= i_wdata[0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      level_q <= '0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      level_q <= level_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pullup_q <= '0;
      core_q <= '0;
      pdm_q <= '0;
      alt_q <= '0;
    end
    else
    begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pullup_q <= pullup_d;
      core_q <= core_d;
      pdm_q <= pdm_d;
      alt_q <= en_w;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_pin_pullup = pullup_q;
  assign o_core_level = core_q;
  assign o_pdm_data = pdm_q;
  assign o_alt_enabled = alt_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence read_val_s;
    i_rd && rd_hit_w;
  endsequence

  sequence read_wo_s;
    i_rd && wr_hit_w;
  endsequence

  read_value_a: assert property (
    read_val_s |=> o_rdata == {15'h0000, $past(rd_level_w)})
    else $error("read-value register returned wrong data");
  write_only_a: assert property (
    read_wo_s |=> o_rdata == 16'h0000)
    else $error("write-value register did not read as zero");
  read_once_a: assert property (
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data present without a read");
  cfg_store_a: assert property (
    (i_wr && mode_hit_w) |=>
      cfg_q[$past(mode_slot_w[4:0])] == $past(i_wdata[CW-1:0]))
    else $error("mode register write was not stored");
  forced_store_a: assert property (
    (i_wr && wr_hit_w) |=>
      forced_q[$past(wr_slot_w[4:0])] == $past(i_wdata[0]))
    else $error("write-value register write was not stored");

  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_chk
      prim_keep_a: assert property (
        !en_w[gi] |=> o_pin_out[gi] == $past(i_prim_out[gi]) &&
                      o_pin_oe[gi] == $past(i_prim_oe[gi]))
        else $error("disabled pin lost its primary function");
      mode_gate_a: assert property (
        !en_w[gi] |=> !o_pin_pullup[gi] && !o_core_level[gi] &&
                      !o_pdm_data[gi])
        else $error("mode acted while pin was disabled");
      pullup_out_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_OUT_PU) |=>
          o_pin_pullup[gi] && o_pin_oe[gi] &&
          o_pin_out[gi] == $past(i_core_out[gi]))
        else $error("output with pull-up misdriven");
      input_float_a: assert property (
        in_mode_w[gi] |=> !o_pin_oe[gi] && !o_pin_pullup[gi])
        else $error("input pin was driven");
      forced_core_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_CP_IN) |=>
          o_core_level[gi] == $past(forced_q[gi]))
        else $error("core value did not follow the written value");
      deb_core_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_GP_IN) |=>
          o_core_level[gi] == $past(stable_w[gi]))
        else $error("plain input did not use the debounced level");
      fault_out_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_FAULT_OUT) |=>
          o_pin_out[gi] == $past(i_fault_flag) && o_pin_oe[gi])
        else $error("fault flag not on pin");
      ss_route_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_SS_OUT &&
         cfg_q[gi][`MPC_SS_MSB:`MPC_SS_LSB] == 3'h0) |=>
          o_pin_out[gi] == $past(i_ss_chan[0]))
        else $error("slave select code 0 not routed to channel 1");
      ss_chan_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_SS_OUT &&
         cfg_q[gi][`MPC_SS_MSB:`MPC_SS_LSB] < 3'(`MPC_SS_CHANNELS)) |=>
          o_pin_out[gi] ==
          $past(i_ss_chan[cfg_q[gi][`MPC_SS_MSB:`MPC_SS_LSB]]))
        else $error("slave select channel misrouted");
      // the line idles high, so an unused channel code must leave it idle
      ss_idle_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_SS_OUT &&
         cfg_q[gi][`MPC_SS_MSB:`MPC_SS_LSB] >= 3'(`MPC_SS_CHANNELS)) |=>
          o_pin_out[gi])
        else $error("unused slave select code drove the line low");
      nopu_out_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_OUT_NOPU) |=>
          !o_pin_pullup[gi] && o_pin_oe[gi] &&
          o_pin_out[gi] == $past(i_core_out[gi]))
        else $error("output without pull-up misdriven");
      pdm_route_a: assert property (
        (en_w[gi] && mode_w[gi] == mpc_pkg::MPC_PDM_IN) |=>
          o_pdm_data[gi] == $past(i_pin_in[gi]))
        else $error("microphone data not passed from the pin");
      alt_copy_a: assert property (
        o_alt_enabled[gi] == $past(en_w[gi]))
        else $error("enable copy out of step with the mode register");
      level_hold_a: assert property (
        !in_mode_w[gi] |=> $stable(level_q[gi]))
        else $error("read value moved while the pin was not an input");
      raw_level_a: assert property (
        (en_w[gi] && (mode_w[gi] == mpc_pkg::MPC_CP_IN ||
                      mode_w[gi] == mpc_pkg::MPC_PDM_IN)) |=>
          level_q[gi] == $past(i_pin_in[gi]))
        else $error("read value did not follow the raw pin");
    end
  endgenerate

endmodule

// file: testbench/mpc_board_model.sv
`timescale 1ns/1ps
`include "mpc_params.svh"
// board side of the pins: a driven pin shows the device level, an undriven
// pin with pull-up reads high, otherwise the level the bench asks for
module mpc_board_model (
  input wire logic [`MPC_NPINS-1:0] i_level,
  input wire logic [`MPC_NPINS-1:0] i_pin_out,
  input wire logic [`MPC_NPINS-1:0] i_pin_oe,
  input wire logic [`MPC_NPINS-1:0] i_pin_pullup,
  output logic [`MPC_NPINS-1:0] o_pin_in
);
  wire [`MPC_NPINS-1:0] pulled = i_pin_pullup | i_level;
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & pulled);
endmodule

// file: testbench/mpc_pin_config_tb_top.sv
`timescale 1ns/1ps
`include "mpc_params.svh"
module mpc_pin_config_tb_top;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [`MPC_NPINS-1:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup;
  logic [`MPC_NPINS-1:0] lvl = '0;
  logic [`MPC_NPINS-1:0] i_prim_out = 26'h2aaaaaa;
  logic [`MPC_NPINS-1:0] i_prim_oe = 26'h1555555;
  logic [`MPC_NPINS-1:0] i_core_out = '0;
  logic i_fault_flag = 1'b0;
  logic [`MPC_SS_CHANNELS-1:0] i_ss_chan = 6'h25;
  logic [`MPC_NPINS-1:0] o_core_level, o_pdm_data, o_alt_enabled;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lim [8] = '{0, 3, 6, 9, 20, 40, 80, 160};
  logic [15:0] d;

  mpc_pin_config #(.DEB_0P3_CYC(3), .DEB_0P6_CYC(6), .DEB_0P9_CYC(9),
    .DEB_5P0_CYC(20), .DEB_10_CYC(40), .DEB_20_CYC(80), .DEB_40_CYC(160))
  mpc_pin_config_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_pin_pullup(o_pin_pullup), .i_prim_out(i_prim_out),
    .i_prim_oe(i_prim_oe), .i_core_out(i_core_out),
    .i_fault_flag(i_fault_flag), .i_ss_chan(i_ss_chan),
    .o_core_level(o_core_level), .o_pdm_data(o_pdm_data),
    .o_alt_enabled(o_alt_enabled));

  mpc_board_model mpc_board_model_i (.i_level(lvl), .i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .i_pin_pullup(o_pin_pullup), .o_pin_in(i_pin_in));

  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end

  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs under a thousand cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      results();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    wait_n(3);
    chk(o_pin_out, i_prim_out);
    chk(o_pin_oe, i_prim_oe);
    chk(o_alt_enabled, 32'h0);
    rd(16'hf530, d); chk(d, 16'h0000);
    rd(16'hf5eb, d); chk(d, 16'h0000);
    rd(16'hf520, d); chk(d, 16'h0000);
    rd(16'hf5ff, d); chk(d, 16'h0000);
    wr(16'hf51d, 16'hffff);
    rd(16'hf51d, d); chk(d, 16'h07ff);
    $display("test reset and map done");

    // disabled pin with an output mode set must stay primary
    @(posedge i_clk);
    i_core_out[5] <= 1'b1;
    wr(16'hf515, 16'h0004);
    wait_n(3);
    chk(o_pin_out[5], i_prim_out[5]);
    chk(o_pin_oe[5], i_prim_oe[5]);
    chk(o_pin_pullup[5], 1'b0);
    @(posedge i_clk);
    i_prim_out <= ~i_prim_out;
    i_prim_oe <= ~i_prim_oe;
    wait_n(3);
    chk(o_pin_out[5], i_prim_out[5]);
    chk(o_pin_oe[5], i_prim_oe[5]);
    $display("test disabled done");

    wr(16'hf512, 16'h0005);
    i_core_out[2] <= 1'b1;
    wait_n(3);
    chk({o_pin_out[2], o_pin_oe[2], o_pin_pullup[2]}, 3'b111);
    @(posedge i_clk);
    i_core_out[2] <= 1'b0;
    wait_n(3);
    chk(o_pin_out[2], 1'b0);
    chk(o_alt_enabled[2], 1'b1);
    wr(16'hf512, 16'h0007);
    i_core_out[2] <= 1'b1;
    wait_n(3);
    chk({o_pin_out[2], o_pin_oe[2], o_pin_pullup[2]}, 3'b110);
    wr(16'hf512, 16'h000b);
    for (int f = 0; f < 2; f++)
    begin
      @(posedge i_clk);
      i_fault_flag <= f[0];
      wait_n(3);
      chk({o_pin_out[2], o_pin_oe[2]}, {f[0], 1'b1});
    end
    for (int s = 0; s < 6; s++)
    begin
      wr(16'hf512, 16'h000d | 16'(s << 8));
      wait_n(3);
      chk(o_pin_out[2], i_ss_chan[s]);
    end
    @(posedge i_clk);
    i_ss_chan <= 6'h1a;
    wait_n(3);
    chk(o_pin_out[2], 1'b0);
    wr(16'hf512, 16'h060d);
    wait_n(3);
    chk(o_pin_out[2], 1'b1);
    $display("test outputs done");

    wr(16'hf513, 16'h0003);
    lvl[3] <= 1'b1;
    wr(16'hf523, 16'h0000);
    wait_n(3);
    chk(o_core_level[3], 1'b0);
    wr(16'hf523, 16'h0001);
    wait_n(3);
    chk(o_core_level[3], 1'b1);
    rd(16'hf533, d); chk(d, 16'h0001);
    wr(16'hf514, 16'h0009);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_clk);
      lvl[4] <= p[0];
      wait_n(4);
      chk(o_pdm_data[4], p[0]);
    end
    wr(16'hf5cb, 16'h0003);
    wr(16'hf5db, 16'h0001);
    wait_n(3);
    chk(o_core_level[25], 1'b1);
    rd(16'hf5eb, d); chk(d, 16'h0000);
    wr(16'hf5c0, 16'h0001);
    lvl[14] <= 1'b1;
    wait_n(6);
    rd(16'hf5e0, d); chk(d, 16'h0001);
    $display("test inputs done");

    // each code: level must hold until the count is used up
    for (int c = 0; c < 8; c++)
    begin
      wr(16'hf510, 16'(c << 4) | 16'h0001);
      wait_n(lim[c] + 6);
      chk(o_core_level[0], 1'b0);
      @(posedge i_clk);
      lvl[0] <= 1'b1;
      // the level must still be old just after the count ends, as the output is registered
      if (lim[c] >= 2)
      begin
        wait_n(lim[c]);
        chk(o_core_level[0], 1'b0);
        wait_n(1);
      end
      else
        wait_n(2);
      chk(o_core_level[0], 1'b1);
      rd(16'hf530, d); chk(d, 16'h0001);
      @(posedge i_clk);
      lvl[0] <= 1'b0;
    end
    wr(16'hf510, 16'h0041);
    wait_n(30);
    @(posedge i_clk);
    lvl[0] <= 1'b1;
    wait_n(10);
    @(posedge i_clk);
    lvl[0] <= 1'b0;
    wait_n(30);
    chk(o_core_level[0], 1'b0);
    wr(16'hf530, 16'h0001);
    rd(16'hf530, d); chk(d, 16'h0000);
    $display("test debounce done");
    results();
  end
endmodule
